// [rtl/tcs_core.sv]
`timescale 1ns/10ps
// What this block does
// - converts continuously from reset, unprompted
// - resolution 9 to 12 bits, 9 default
// - conversion time doubles per added bit
// - 9-bit conversion ends within 25 ms
// - result stored as 16-bit two's complement
// - top bit is the sign
// - bit 14 weighs 2^6, bit 4 2^-4
// - bits 3..0 always zero
// - unused low bits zero at lower resolution
// - reads never disturb a running conversion
// - shutdown finishes and stores, then stops
// - shutdown entry clears alert in interrupt mode
// - link stays live; clearing shutdown resumes
// - own SDA low too long releases line
// - others holding SDA low never time out
// - shutdown bit 0 converts, 1 stops, resets 0
// - alert mode 0 comparator, 1 interrupt
module tcs_core
  import tcs_pkg::*;
#(
  parameter int CONV_CYCLES = CONV9_CYCLES,
  parameter int HANG_CYCLES = TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic linkClk,
  input wire logic linkRstn,
  input wire logic [SAMPLE_WIDTH-1:0] rawSample,
  input wire logic powerDownRequest,
  input wire logic alertBehaviourSelect,
  input wire logic resolutionCodeLow,
  input wire logic resolutionCodeHigh,
  input wire logic sdaHoldReq,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic linkSdaIn,
  output logic serialIfReset,
  output logic [15:0] temperatureReading,
  output logic conversionDone,
  output logic standby,
  output logic alertClear
);

  // ****************************************************************
  // crossings into the core domain
  // ****************************************************************
  logic [CTL_WIDTH-1:0] ctlLink;
  logic [CTL_WIDTH-1:0] ctlSync;
  logic pdReq;
  logic intrMode;
  logic [1:0] resCode;
  logic holdReq;

  // config bits written on the link side, plus our own SDA hold request
  assign ctlLink[CTL_PDR] = powerDownRequest;
  assign ctlLink[CTL_ABS] = alertBehaviourSelect;
  assign ctlLink[CTL_RESLO] = resolutionCodeLow;
  assign ctlLink[CTL_RESHI] = resolutionCodeHigh;
  assign ctlLink[CTL_HOLD] = sdaHoldReq;

  tcs_sync #(
    .WIDTH(CTL_WIDTH)
  ) u_core_sync (
    .clk(clk),
    .rstn(rstn),
    .d(ctlLink),
    .q(ctlSync)
  );

  // decoded control levels, core side
  assign pdReq = ctlSync[CTL_PDR];
  assign intrMode = ctlSync[CTL_ABS];
  assign resCode = {ctlSync[CTL_RESHI], ctlSync[CTL_RESLO]};
  assign holdReq = ctlSync[CTL_HOLD];

  // ****************************************************************
  // resolution code agreement
  // ****************************************************************
  logic [1:0] resPrev_reg;
  logic [1:0] resStable_reg;

  // the two code bits cross apart; a code is taken only when two
  // samples agree, so a split change never starts a mixed conversion
  always_ff @(posedge clk) begin
    if (!rstn) begin
      resPrev_reg <= RES_RESET;
      resStable_reg <= RES_RESET;
    end else begin
      resPrev_reg <= resCode;
      if (resCode == resPrev_reg) begin
        resStable_reg <= resCode;
      end
    end
  end

  // ****************************************************************
  // conversion sequencer
  // ****************************************************************
  tcs_state_t state_reg;
  logic [31:0] count_reg;
  logic [1:0] resActive_reg;
  logic [15:0] tempWord_reg;
  logic updToggle_reg;
  logic convDone_reg;
  logic alertClear_reg;
  logic lastCycle;
  logic [31:0] nextLen;
  logic [15:0] resMask;
  logic [15:0] sampleWord;

  // final counting cycle of a running conversion
  assign lastCycle = (state_reg == TCS_CONVERTING) && (count_reg == 32'h0);

  // length of the next conversion, doubling per added bit
  assign nextLen = (CONV_CYCLES[31:0] << resStable_reg) - 32'h1;

  // result mask per active resolution
  always_comb begin
    unique case (resActive_reg)
      RES_9BIT: resMask = MASK_9BIT;
      RES_10BIT: resMask = MASK_10BIT;
      RES_11BIT: resMask = MASK_11BIT;
      RES_12BIT: resMask = MASK_12BIT;
    endcase
  end

  // sample in 1/16 degree units lands on bits 15..4, sign on top
  assign sampleWord = {rawSample, {LOW_ZERO_BITS{1'b0}}} & resMask;

  // state: converting from reset, standby only after a stored result
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= TCS_CONVERTING;
    end else begin
      unique case (state_reg)
        TCS_CONVERTING: begin
          if (lastCycle && pdReq) begin
            state_reg <= TCS_STANDBY;
          end
        end
        TCS_STANDBY: begin
          if (!pdReq) begin
            state_reg <= TCS_CONVERTING;
          end
        end
      endcase
    end
  end

  // cycle counter; the resolution is caught only when a new run starts
  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_reg <= CONV_CYCLES[31:0] - 32'h1;
      resActive_reg <= RES_RESET;
    end else if (state_reg == TCS_CONVERTING) begin
      if (count_reg == 32'h0) begin
        count_reg <= nextLen;
        resActive_reg <= resStable_reg;
      end else begin
        count_reg <= count_reg - 32'h1;
      end
    end else if (!pdReq) begin
      count_reg <= nextLen;
      resActive_reg <= resStable_reg;
    end
  end

  // done strobe, raised on the same edge as each store
  always_ff @(posedge clk) begin
    if (!rstn) begin
      convDone_reg <= 1'b0;
    end else begin
      convDone_reg <= lastCycle;
    end
  end

  // result store; a pending shutdown still gets its result
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tempWord_reg <= TEMP_RESET;
      updToggle_reg <= 1'b0;
    end else begin
      if (lastCycle) begin
        tempWord_reg <= sampleWord;
        updToggle_reg <= ~updToggle_reg;
      end
    end
  end

  // alert clear on the way into standby, interrupt mode only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      alertClear_reg <= 1'b0;
    end else begin
      alertClear_reg <= lastCycle && pdReq && intrMode;
    end
  end

  // sequencer outputs, all straight from registers
  assign conversionDone = convDone_reg;
  assign alertClear = alertClear_reg;
  assign standby = (state_reg == TCS_STANDBY);

  // ****************************************************************
  // bus-hang watchdog
  // ****************************************************************
  logic [31:0] hangCount_reg;
  logic timedOut_reg;
  logic sdaOe_reg;
  logic hangDue;

  // terminal count of the hang timer
  assign hangDue = (hangCount_reg == HANG_CYCLES[31:0] - 32'h1);

  // counts only while this device itself pulls SDA low; the pin level
  // is never looked at, so a foreign low cannot trip it
  always_ff @(posedge clk) begin
    if (!rstn || !holdReq) begin
      hangCount_reg <= 32'h0;
    end else if (!hangDue) begin
      hangCount_reg <= hangCount_reg + 32'h1;
    end
  end

  // timeout flag; cleared only when our own request goes away
  always_ff @(posedge clk) begin
    if (!rstn || !holdReq) begin
      timedOut_reg <= 1'b0;
    end else if (hangDue) begin
      timedOut_reg <= 1'b1;
    end
  end

  // drive low only while asked and not timed out
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sdaOe_reg <= 1'b0;
    end else begin
      sdaOe_reg <= holdReq && !timedOut_reg;
    end
  end

  // open drain: only the enable ever moves
  assign sdaOe = sdaOe_reg;
  assign sdaOut = 1'b0;

  // ****************************************************************
  // link-side logic
  // ****************************************************************
  logic [LNK_WIDTH-1:0] lnkIn;
  logic [LNK_WIDTH-1:0] lnkSync;
  logic updSeen_reg;
  logic [15:0] tempRead_reg;
  logic updEdge;

  // carried inverted so the cleared synchroniser reads as an idle high
  // line; a false falling edge out of reset could look like a start
  assign lnkIn[LNK_SDA] = ~sdaIn;
  assign lnkIn[LNK_TMO] = timedOut_reg;
  assign lnkIn[LNK_UPD] = updToggle_reg;

  tcs_sync #(
    .WIDTH(LNK_WIDTH)
  ) u_link_sync (
    .clk(linkClk),
    .rstn(linkRstn),
    .d(lnkIn),
    .q(lnkSync)
  );

  // a changed toggle level marks a fresh result
  assign updEdge = (lnkSync[LNK_UPD] != updSeen_reg);

  // result word is held still for milliseconds after each toggle,
  // so taking it on the synced edge is safe
  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      tempRead_reg <= TEMP_RESET;
    end else if (updEdge) begin
      tempRead_reg <= tempWord_reg;
    end
  end

  // last toggle level seen on the link side
  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      updSeen_reg <= 1'b0;
    end else begin
      updSeen_reg <= lnkSync[LNK_UPD];
    end
  end

  // reads only look at this copy; nothing flows back to the sequencer
  assign temperatureReading = tempRead_reg;
  assign serialIfReset = lnkSync[LNK_TMO];
  assign linkSdaIn = ~lnkSync[LNK_SDA];

endmodule

// [rtl/tcs_pkg.sv]
package tcs_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_MHZ = 200;
  // longest 9-bit conversion, rounded down to whole cycles
  localparam int CONV9_TIME_US = 25000;
  localparam int CONV9_CYCLES = (CONV9_TIME_US * CLK_MHZ);
  // least bus-hang time before the data line is let go
  localparam int TIMEOUT_MIN_MS = 75;
  localparam int TIMEOUT_CYCLES = (TIMEOUT_MIN_MS * 1000 * CLK_MHZ);

  // ****************************************************************
  // resolution codes and result layout
  // ****************************************************************
  localparam logic [1:0] RES_9BIT = 2'h0;
  localparam logic [1:0] RES_10BIT = 2'h1;
  localparam logic [1:0] RES_11BIT = 2'h2;
  localparam logic [1:0] RES_12BIT = 2'h3;
  localparam logic [1:0] RES_RESET = RES_9BIT;
  localparam logic [15:0] MASK_9BIT = 16'hff80;
  localparam logic [15:0] MASK_10BIT = 16'hffc0;
  localparam logic [15:0] MASK_11BIT = 16'hffe0;
  localparam logic [15:0] MASK_12BIT = 16'hfff0;
  localparam int SAMPLE_WIDTH = 12;
  localparam int LOW_ZERO_BITS = 4;
  localparam logic [15:0] TEMP_RESET = 16'h0000;

  // ****************************************************************
  // control bits carried across from the link side
  // ****************************************************************
  localparam int CTL_WIDTH = 5;
  localparam int CTL_PDR = 0;
  localparam int CTL_ABS = 1;
  localparam int CTL_RESLO = 2;
  localparam int CTL_RESHI = 3;
  localparam int CTL_HOLD = 4;
  // link-side return vector
  localparam int LNK_WIDTH = 3;
  localparam int LNK_SDA = 0;
  localparam int LNK_TMO = 1;
  localparam int LNK_UPD = 2;

  typedef enum logic {
    TCS_CONVERTING = 1'b0,
    TCS_STANDBY = 1'b1
  } tcs_state_t;

endpackage

// [rtl/tcs_sync.sv]
`timescale 1ns/10ps
// two-flop level synchroniser, one stage pair per bit
module tcs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // ****************************************************************
  // stages
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // first stage feeds only the second
      always_ff @(posedge clk) begin
        if (!rstn) begin
          meta_reg[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta_reg[i] <= d[i];
          q[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule

// [tb/tcs_bus_model.sv]
`timescale 1ns/10ps
// ****
// pulled-up data line with a second agent on it
// ****
module tcs_bus_model (
  input wire logic sdaOe,
  input wire logic sdaOut,
  input wire logic otherHold,
  output logic sdaIn
);
  // open drain: any driver low wins, else the pull-up
  assign sdaIn = ((sdaOe && !sdaOut) || otherHold) ? 1'b0 : 1'b1;
endmodule

// [tb/tcs_core_checker.sv]
`timescale 1ns/10ps
// ****
// conversion, standby and bus-hang checks
// ****
module tcs_core_checker #(
  parameter int HANG_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic linkClk,
  input wire logic linkRstn,
  input wire logic [15:0] temperatureReading,
  input wire logic conversionDone,
  input wire logic standby,
  input wire logic alertClear,
  input wire logic powerDownRequest,
  input wire logic sdaHoldReq,
  input wire logic sdaOe,
  input wire logic serialIfReset
);
  logic [31:0] oeRun_reg;
  // length of the current pull-low run; too long means a hung bus
  always_ff @(posedge clk) begin
    oeRun_reg <= (!rstn || !sdaOe) ? '0 : oeRun_reg + 32'h1;
  end
  AST_LOW_ZERO: assert property (@(posedge linkClk)
    disable iff (!linkRstn) temperatureReading[3:0] == 4'h0)
    else $error("low bits of reading not zero");
  AST_DONE_GAP: assert property (@(posedge clk) disable iff (!rstn)
    conversionDone |=> !conversionDone [*8]) else $error("done too soon");
  AST_STBY_QUIET: assert property (@(posedge clk)
    disable iff (!rstn) standby ##1 standby |-> !conversionDone)
    else $error("conversion finished in standby");
  AST_STBY_ENTRY: assert property (@(posedge clk)
    disable iff (!rstn) $rose(standby) |-> conversionDone)
    else $error("standby entered mid-conversion");
  AST_ALERT_CLR: assert property (@(posedge clk)
    disable iff (!rstn) alertClear |-> $rose(standby))
    else $error("alert clear outside standby entry");
  AST_STBY_EXIT: assert property (@(posedge clk)
    disable iff (!rstn) $fell(standby) |-> !powerDownRequest)
    else $error("standby left while still requested");
  AST_OE_ARM: assert property (@(posedge clk) disable iff (!rstn)
    $rose(sdaHoldReq) && !serialIfReset |-> ##[1:4] sdaOe)
    else $error("data line not pulled");
  AST_OE_LIMIT: assert property (@(posedge clk)
    disable iff (!rstn) sdaOe |-> oeRun_reg < HANG_CYCLES + 1)
    else $error("data line held past timeout");
  cover property (@(posedge clk) $rose(standby) && alertClear);
  cover property (@(posedge clk) $fell(sdaOe) && sdaHoldReq);
  cover property (@(posedge clk) $fell(standby));
endmodule
bind tcs_core tcs_core_checker #(.HANG_CYCLES(HANG_CYCLES)) u_chk (.clk,
  .rstn, .linkClk, .linkRstn, .temperatureReading, .conversionDone,
  .standby, .alertClear, .powerDownRequest, .sdaHoldReq, .sdaOe,
  .serialIfReset);

// [tb/temp_conversion_shutdown_bench.sv]
`timescale 1ns/10ps
module temp_conversion_shutdown_bench;
  localparam int CONV = 20;
  localparam int HANG = 50;
  logic clk = 0, linkClk = 0, rstn = 0, linkRstn = 0;
  logic powerDownRequest = 0, alertBehaviourSelect = 0;
  logic resolutionCodeLow = 0, resolutionCodeHigh = 0;
  logic sdaHoldReq = 0, otherHold = 0;
  logic [11:0] rawSample = 12'h000;
  logic sdaIn, sdaOut, sdaOe, linkSdaIn, serialIfReset;
  logic conversionDone, standby, alertClear;
  logic [15:0] temperatureReading;
  logic [15:0] mask [4] = '{16'hff80, 16'hffc0, 16'hffe0, 16'hfff0};
  logic [11:0] samp [3] = '{12'h7d0, 12'hff8, 12'hc90};
  int failures = 0, n_compared = 0, cyc = 0, n;
  // ****
  // clocks, design and bus
  // ****
  always #2.5 clk = ~clk;
  initial #1.3 forever #6 linkClk = ~linkClk;
  tcs_core #(.CONV_CYCLES(CONV), .HANG_CYCLES(HANG)) u_dut (.clk, .rstn,
    .linkClk, .linkRstn, .rawSample, .powerDownRequest,
    .alertBehaviourSelect, .resolutionCodeLow, .resolutionCodeHigh,
    .sdaHoldReq, .sdaIn, .sdaOut, .sdaOe, .linkSdaIn, .serialIfReset,
    .temperatureReading, .conversionDone, .standby, .alertClear);
  tcs_bus_model u_bus (.sdaOe, .sdaOut, .otherHold, .sdaIn);
  // ****
  // helpers
  // ****
  task automatic check(string what, logic [15:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // counts falling edges up to the next done strobe
  task automatic waitDone(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (conversionDone !== 1'b1);
  endtask
  task automatic results;
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, far above the few thousand cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  // ****
  // test sequence
  // ****
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1;
    linkRstn = 1;
    check("reading", 16'h0000, temperatureReading);
    rawSample = 12'he6f;
    waitDone(n);
    check("first", 16'(CONV), 16'(n));
    repeat (8) @(negedge linkClk);
    check("default", 16'he680, temperatureReading);
    for (int r = 0; r < 4; r++) begin
      {resolutionCodeHigh, resolutionCodeLow} = r[1:0];
      waitDone(n);
      waitDone(n);
      waitDone(n);
      check("period", 16'(CONV << r), 16'(n));
      repeat (8) @(negedge linkClk);
      check("reading", 16'he6f0 & mask[r], temperatureReading);
    end
    for (int i = 0; i < 3; i++) begin
      rawSample = samp[i];
      waitDone(n);
      repeat (8) @(negedge linkClk);
      check("sample", {samp[i], 4'h0}, temperatureReading);
    end
    for (int m = 1; m >= 0; m--) begin
      alertBehaviourSelect = m[0];
      rawSample = 12'h191;
      powerDownRequest = 1;
      waitDone(n);
      check("standby", 16'h1, 16'(standby));
      check("alertClear", 16'(m), 16'(alertClear));
      rawSample = 12'h0a2;
      n = 0;
      repeat (400) @(negedge clk) if (conversionDone === 1'b1) n++;
      check("quiet", 16'h0, 16'(n));
      check("held", 16'h1910, temperatureReading);
      powerDownRequest = 0;
      waitDone(n);
      check("resume", 16'h1, 16'(n <= (CONV << 3) + 8));
      repeat (8) @(negedge linkClk);
      check("resumed", 16'h0a20, temperatureReading);
    end
    otherHold = 1;
    repeat (2 * HANG) @(negedge clk);
    check("oe other", 16'h0, 16'(sdaOe));
    check("ifrst other", 16'h0, 16'(serialIfReset));
    check("sda other", 16'h0, 16'(linkSdaIn));
    otherHold = 0;
    sdaHoldReq = 1;
    repeat (HANG) @(negedge clk);
    check("oe held", 16'h1, 16'(sdaOe));
    check("sda low", 16'h0, 16'(sdaIn));
    repeat (20) @(negedge clk);
    check("oe free", 16'h0, 16'(sdaOe));
    check("ifrst", 16'h1, 16'(serialIfReset));
    check("sda seen", 16'h1, 16'(linkSdaIn));
    sdaHoldReq = 0;
    repeat (30) @(negedge clk);
    check("ifrst off", 16'h0, 16'(serialIfReset));
    results();
  end
endmodule
